//--- cwism_checker.sv
// concurrent checks on the ports of the comparator status and mask block
`timescale 1ns/100ps
module cwism_checker (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus request side
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    // event and reset sources
    input wire bus_supply_sense,
    input wire wake_cause_off,
    input wire pm_sm_reset,
    input wire [15:0] charger_clock_flags,
    // outputs watched
    input wire irq_request,
    input wire mask_battery_overtemp,
    input wire [15:0] system_event_mask,
    input wire [15:0] charger_clock_event_mask
);
    // write address phase taken, and charger sources left unmasked
    wire wr_go = hsel && htrans[1] && hready && hwrite;
    wire [15:0] chg_live = charger_clock_flags & ~charger_clock_event_mask & 16'hFEE7;
    logic live_q;

    // edge checks wait one cycle after reset, the detectors start from zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_pm_clear;
        pm_sm_reset |=> system_event_mask == 16'h0000 && charger_clock_event_mask == 16'h0000;
    endproperty
    a_pm_clear: assert property (p_pm_clear)
        else $error("masks not cleared by power state reset");

    property p_sys_write;
        wr_go && haddr == 32'h00000080 ##1 !pm_sm_reset
            |=> {16'h0000, system_event_mask} == ($past(hwdata) & 32'h0000FFFF);
    endproperty
    a_sys_write: assert property (p_sys_write)
        else $error("system mask did not take written value");

    property p_chg_write;
        wr_go && haddr == 32'h00000084 ##1 !pm_sm_reset
            |=> {16'h0000, charger_clock_event_mask} == ($past(hwdata) & 32'h0000FEE7);
    endproperty
    a_chg_write: assert property (p_chg_write)
        else $error("charger mask did not take written value");

    property p_mask_pin;
        mask_battery_overtemp == charger_clock_event_mask[15];
    endproperty
    a_mask_pin: assert property (p_mask_pin)
        else $error("overtemp mask pin differs from register");

    property p_sense_change;
        live_q && $changed(bus_supply_sense) |=> system_event_mask[15] || irq_request;
    endproperty
    a_sense_change: assert property (p_sense_change)
        else $error("supply sense change raised no request");

    property p_wake_rise;
        live_q && $rose(wake_cause_off) |=> system_event_mask[6] || irq_request;
    endproperty
    a_wake_rise: assert property (p_wake_rise)
        else $error("wake from off raised no request");

    property p_masked_quiet;
        system_event_mask == 16'hFFFF && chg_live == 16'h0000 |-> !irq_request;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("request raised with every source masked");

    property p_chg_request;
        chg_live != 16'h0000 |-> irq_request;
    endproperty
    a_chg_request: assert property (p_chg_request)
        else $error("unmasked charger flag gave no request");
endmodule

bind cwism_top cwism_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .bus_supply_sense(bus_supply_sense), .wake_cause_off(wake_cause_off),
    .pm_sm_reset(pm_sm_reset), .charger_clock_flags(charger_clock_flags),
    .irq_request(irq_request), .mask_battery_overtemp(mask_battery_overtemp),
    .system_event_mask(system_event_mask),
    .charger_clock_event_mask(charger_clock_event_mask)
);

//--- cwism_defs.vh
// register map, field positions and reset values of the comparator status and mask block
`ifndef CWISM_DEFS_VH
`define CWISM_DEFS_VH

// register indices as printed, byte address is four times the index
`define CWISM_IDX_STATUS 8'h1F
`define CWISM_IDX_SYS_MASK 8'h20
`define CWISM_IDX_CHG_MASK 8'h21

// reset values
`define CWISM_STATUS_RESET 16'h0000
`define CWISM_MASK_RESET 16'h0000

// status bit positions
`define CWISM_BIT_BUS_SUPPLY 15
`define CWISM_BIT_ADAPTOR_SUPPLY 14
`define CWISM_BIT_BATTERY 13
`define CWISM_BIT_LEFT_JACK 11
`define CWISM_BIT_RIGHT_JACK 10
`define CWISM_BIT_MIC_SHORT 9
`define CWISM_BIT_MIC_PRESENCE 8
`define CWISM_BIT_FROM_OFF 6
`define CWISM_BIT_FROM_HIBERNATE 5
`define CWISM_BIT_CONV_FAULT 4
`define CWISM_BIT_WATCHDOG 3
`define CWISM_BIT_POWER_PIN 2
`define CWISM_BIT_ON_KEY 1
`define CWISM_BIT_WAKE_PIN 0

// implemented status bits and those that fire on both edges
`define CWISM_STATUS_IMPL 16'hEF7F
`define CWISM_STATUS_BOTH 16'hEF00

// charger and clock mask bit positions
`define CWISM_BIT_M_BATT_HOT 15
`define CWISM_BIT_M_BATT_COLD 14
`define CWISM_BIT_M_BATT_FAIL 13
`define CWISM_BIT_M_CHG_TIMEOUT 12
`define CWISM_BIT_M_CHG_DONE 11
`define CWISM_BIT_M_CHG_BEGUN 10
`define CWISM_BIT_M_FAST_READY 9
`define CWISM_BIT_M_CLK_PERIODIC 7
`define CWISM_BIT_M_CLK_SECONDS 6
`define CWISM_BIT_M_CLK_ALARM 5
`define CWISM_BIT_M_BATT_HIGH 2
`define CWISM_BIT_M_BATT_MID 1
`define CWISM_BIT_M_BATT_LOW 0

// writable bits of the two mask registers
`define CWISM_CHG_MASK_IMPL 16'hFEE7
`define CWISM_SYS_MASK_IMPL 16'hFFFF

// bus answer codes
`define CWISM_HRESP_OKAY 1'b0
`define CWISM_RDATA_UNMAPPED 32'h00000000

`endif

//--- cwism_edge_flags.v
// edge detectors and sticky clear-on-read flags of the comparator status register
`timescale 1ns/100ps
module cwism_edge_flags #(
    parameter [15:0] IMPL_MASK = 16'hFFFF,
    parameter [15:0] BOTH_MASK = 16'h0000
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // detector levels, one per flag
    input wire [15:0] level_in,
    // one-cycle clear request, per flag
    input wire [15:0] clear_in,
    // sticky flags
    output wire [15:0] flags_out
);

    reg [15:0] level_q;
    reg [15:0] flags_q;
    wire [15:0] rise;
    wire [15:0] fall;
    wire [15:0] set_ev;
    wire [15:0] flags_d;

    // previous level; starts low, so a cause high at reset release counts as a rise
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= 16'h0000;
        end else begin
            level_q <= level_in;
        end
    end

    // both-edge bits take either change, the others only the rise
    assign rise = level_in & ~level_q;
    assign fall = ~level_in & level_q;
    assign set_ev = (rise | (fall & BOTH_MASK)) & IMPL_MASK;

    // set wins over clear so an event during the clearing read survives
    assign flags_d = ((flags_q & ~clear_in) | set_ev) & IMPL_MASK;

    // flags start cleared
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= 16'h0000;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_out = flags_q;

endmodule

//--- cwism_top.v
// comparator and wake status register with two interrupt mask registers on AHB-Lite
`timescale 1ns/100ps
`include "cwism_defs.vh"
module cwism_top (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    // comparator detector levels
    input wire bus_supply_sense,
    input wire adaptor_supply_sense,
    input wire battery_sense,
    input wire left_jack_detect,
    input wire right_jack_detect,
    input wire mic_short_detect,
    input wire mic_presence_detect,
    // wake cause levels
    input wire wake_cause_off,
    input wire wake_cause_hibernate,
    input wire wake_cause_converter_fault,
    input wire wake_cause_watchdog,
    input wire power_button_pin_held,
    input wire on_key_held,
    input wire wake_request_pin_held,
    // power state machine reset, synchronous, active high
    input wire pm_sm_reset,
    // flags of the charger and clock status register kept elsewhere
    input wire [15:0] charger_clock_flags,
    // combined request from this block's status flags and the unmasked charger and clock flags
    output wire irq_request,
    // mask levels for the charger and clock sources
    output wire mask_battery_overtemp,
    output wire mask_battery_undertemp,
    output wire mask_battery_failure,
    output wire mask_charge_timeout,
    output wire mask_charge_done,
    output wire mask_charge_begun,
    output wire mask_fast_charge_ready,
    output wire mask_clock_periodic,
    output wire mask_clock_seconds_tick,
    output wire mask_clock_alarm,
    output wire mask_battery_below_high_level,
    output wire mask_battery_below_mid_level,
    output wire mask_battery_below_low_level,
    // full mask words
    output wire [15:0] system_event_mask,
    output wire [15:0] charger_clock_event_mask
);

    // register selectors
    localparam [1:0] SEL_NONE = 2'h0;
    localparam [1:0] SEL_STATUS = 2'h1;
    localparam [1:0] SEL_SYS_MASK = 2'h2;
    localparam [1:0] SEL_CHG_MASK = 2'h3;

    // data phase states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_READ = 2'h1;
    localparam [1:0] ST_WRITE = 2'h2;

    // map a byte address to a register selector
    function [1:0] decode;
        input [31:0] addr;
        begin
            if (addr[31:10] != 22'h000000 || addr[1:0] != 2'h0) begin
                decode = SEL_NONE;
            end else if (addr[9:2] == `CWISM_IDX_STATUS) begin
                decode = SEL_STATUS;
            end else if (addr[9:2] == `CWISM_IDX_SYS_MASK) begin
                decode = SEL_SYS_MASK;
            end else if (addr[9:2] == `CWISM_IDX_CHG_MASK) begin
                decode = SEL_CHG_MASK;
            end else begin
                decode = SEL_NONE;
            end
        end
    endfunction

    // next value of a mask register
    function [15:0] mask_next;
        input [15:0] cur;
        input do_write;
        input [15:0] wdata;
        input [15:0] impl;
        input sm_reset;
        begin
            if (sm_reset) begin
                mask_next = `CWISM_MASK_RESET;
            end else if (do_write) begin
                mask_next = wdata & impl;
            end else begin
                mask_next = cur;
            end
        end
    endfunction

    // bus state
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] sel_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;

    // register contents
    reg [15:0] sys_mask_q;
    reg [15:0] chg_mask_q;
    wire [15:0] sys_mask_d;
    wire [15:0] chg_mask_d;

    // status flags
    wire [15:0] cause_vec;
    wire [15:0] status_flags;
    wire [15:0] status_clear;

    // address phase qualifiers and data phase write strobes
    wire addr_valid;
    wire [1:0] addr_sel;
    wire read_req;
    wire write_req;
    wire write_sys;
    wire write_chg;

    // named flags for readability of the status layout
    wire bus_supply_sense_change_flag;
    wire adaptor_supply_sense_change_flag;
    wire battery_sense_change_flag;
    wire left_jack_change_flag;
    wire right_jack_change_flag;
    wire mic_short_change_flag;
    wire mic_presence_change_flag;
    wire woke_from_off_flag;
    wire woke_from_hibernate_flag;
    wire woke_after_converter_fault_flag;
    wire woke_after_watchdog_reset_flag;
    wire power_button_pin_hold_flag;
    wire on_key_hold_flag;
    wire wake_request_pin_hold_flag;

    // gather the detector and wake cause levels into status positions
    assign cause_vec[`CWISM_BIT_BUS_SUPPLY] = bus_supply_sense;
    assign cause_vec[`CWISM_BIT_ADAPTOR_SUPPLY] = adaptor_supply_sense;
    assign cause_vec[`CWISM_BIT_BATTERY] = battery_sense;
    assign cause_vec[12] = 1'b0;
    assign cause_vec[`CWISM_BIT_LEFT_JACK] = left_jack_detect;
    assign cause_vec[`CWISM_BIT_RIGHT_JACK] = right_jack_detect;
    assign cause_vec[`CWISM_BIT_MIC_SHORT] = mic_short_detect;
    assign cause_vec[`CWISM_BIT_MIC_PRESENCE] = mic_presence_detect;
    assign cause_vec[7] = 1'b0;
    assign cause_vec[`CWISM_BIT_FROM_OFF] = wake_cause_off;
    assign cause_vec[`CWISM_BIT_FROM_HIBERNATE] = wake_cause_hibernate;
    assign cause_vec[`CWISM_BIT_CONV_FAULT] = wake_cause_converter_fault;
    assign cause_vec[`CWISM_BIT_WATCHDOG] = wake_cause_watchdog;
    assign cause_vec[`CWISM_BIT_POWER_PIN] = power_button_pin_held;
    assign cause_vec[`CWISM_BIT_ON_KEY] = on_key_held;
    assign cause_vec[`CWISM_BIT_WAKE_PIN] = wake_request_pin_held;

    // edge detection and sticky flags; wake bits are rise only
    cwism_edge_flags #(
        .IMPL_MASK(`CWISM_STATUS_IMPL),
        .BOTH_MASK(`CWISM_STATUS_BOTH)
    ) u_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .level_in(cause_vec),
        .clear_in(status_clear),
        .flags_out(status_flags)
    );

    // names of the individual flags
    assign bus_supply_sense_change_flag = status_flags[`CWISM_BIT_BUS_SUPPLY];
    assign adaptor_supply_sense_change_flag = status_flags[`CWISM_BIT_ADAPTOR_SUPPLY];
    assign battery_sense_change_flag = status_flags[`CWISM_BIT_BATTERY];
    assign left_jack_change_flag = status_flags[`CWISM_BIT_LEFT_JACK];
    assign right_jack_change_flag = status_flags[`CWISM_BIT_RIGHT_JACK];
    assign mic_short_change_flag = status_flags[`CWISM_BIT_MIC_SHORT];
    assign mic_presence_change_flag = status_flags[`CWISM_BIT_MIC_PRESENCE];
    assign woke_from_off_flag = status_flags[`CWISM_BIT_FROM_OFF];
    assign woke_from_hibernate_flag = status_flags[`CWISM_BIT_FROM_HIBERNATE];
    assign woke_after_converter_fault_flag = status_flags[`CWISM_BIT_CONV_FAULT];
    assign woke_after_watchdog_reset_flag = status_flags[`CWISM_BIT_WATCHDOG];
    assign power_button_pin_hold_flag = status_flags[`CWISM_BIT_POWER_PIN];
    assign on_key_hold_flag = status_flags[`CWISM_BIT_ON_KEY];
    assign wake_request_pin_hold_flag = status_flags[`CWISM_BIT_WAKE_PIN];

    // address phase: only nonseq or seq transfers with hready high are taken
    assign addr_valid = hsel & htrans[1] & hready;
    assign addr_sel = decode(haddr);
    assign read_req = addr_valid & ~hwrite;
    assign write_req = addr_valid & hwrite;

    // the read itself clears the status, the event path wins in the flag module
    assign status_clear = (read_req && addr_sel == SEL_STATUS) ? 16'hFFFF : 16'h0000;

    // writes land in the data phase, when hwdata is valid
    assign write_sys = (state_q == ST_WRITE) && (sel_q == SEL_SYS_MASK);
    assign write_chg = (state_q == ST_WRITE) && (sel_q == SEL_CHG_MASK);

    // state machine reset beats a write in the same cycle
    assign sys_mask_d = mask_next(sys_mask_q, write_sys, hwdata[15:0],
        `CWISM_SYS_MASK_IMPL, pm_sm_reset);
    assign chg_mask_d = mask_next(chg_mask_q, write_chg, hwdata[15:0],
        `CWISM_CHG_MASK_IMPL, pm_sm_reset);

    // mask registers default to zero, meaning every source enabled
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_mask_q <= `CWISM_MASK_RESET;
            chg_mask_q <= `CWISM_MASK_RESET;
        end else begin
            sys_mask_q <= sys_mask_d;
            chg_mask_q <= chg_mask_d;
        end
    end

    // data phase tracking; zero wait states so every taken request ends next cycle
    always @* begin
        state_d = ST_IDLE;
        case (state_q)
            ST_IDLE, ST_READ, ST_WRITE: begin
                if (read_req) begin
                    state_d = ST_READ;
                end else if (write_req) begin
                    state_d = ST_WRITE;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // read data is caught at the address edge; mask reads see a write in flight
    always @* begin
        rdata_d = `CWISM_RDATA_UNMAPPED;
        if (read_req) begin
            case (addr_sel)
                SEL_STATUS: begin
                    rdata_d = {16'h0000, status_flags};
                end
                SEL_SYS_MASK: begin
                    rdata_d = {16'h0000, sys_mask_d};
                end
                SEL_CHG_MASK: begin
                    rdata_d = {16'h0000, chg_mask_d};
                end
                default: begin
                    rdata_d = `CWISM_RDATA_UNMAPPED;
                end
            endcase
        end
    end

    // bus registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            sel_q <= SEL_NONE;
            rdata_q <= 32'h00000000;
        end else begin
            state_q <= state_d;
            sel_q <= addr_valid ? addr_sel : SEL_NONE;
            rdata_q <= rdata_d;
        end
    end

    // never stalls, never errors; unmapped reads return zero, unmapped writes drop
    assign hreadyout = 1'b1;
    assign hresp = `CWISM_HRESP_OKAY;
    assign hrdata = rdata_q;

    // masked flags stay latched but are kept out of the combined request
    assign irq_request = |(status_flags & ~sys_mask_q) |
        |(charger_clock_flags & ~chg_mask_q & `CWISM_CHG_MASK_IMPL);

    // mask levels for the charger and clock sources, 1 suppresses
    assign mask_battery_overtemp = chg_mask_q[`CWISM_BIT_M_BATT_HOT];
    assign mask_battery_undertemp = chg_mask_q[`CWISM_BIT_M_BATT_COLD];
    assign mask_battery_failure = chg_mask_q[`CWISM_BIT_M_BATT_FAIL];
    assign mask_charge_timeout = chg_mask_q[`CWISM_BIT_M_CHG_TIMEOUT];
    assign mask_charge_done = chg_mask_q[`CWISM_BIT_M_CHG_DONE];
    assign mask_charge_begun = chg_mask_q[`CWISM_BIT_M_CHG_BEGUN];
    assign mask_fast_charge_ready = chg_mask_q[`CWISM_BIT_M_FAST_READY];
    assign mask_clock_periodic = chg_mask_q[`CWISM_BIT_M_CLK_PERIODIC];
    assign mask_clock_seconds_tick = chg_mask_q[`CWISM_BIT_M_CLK_SECONDS];
    assign mask_clock_alarm = chg_mask_q[`CWISM_BIT_M_CLK_ALARM];
    assign mask_battery_below_high_level = chg_mask_q[`CWISM_BIT_M_BATT_HIGH];
    assign mask_battery_below_mid_level = chg_mask_q[`CWISM_BIT_M_BATT_MID];
    assign mask_battery_below_low_level = chg_mask_q[`CWISM_BIT_M_BATT_LOW];

    // full words for the neighbouring status blocks
    assign system_event_mask = sys_mask_q;
    assign charger_clock_event_mask = chg_mask_q;

endmodule

//--- cwism_top_test.sv
// self-checking bench for the comparator status and mask block
`timescale 1ns/100ps
`include "cwism_defs.vh"
module cwism_top_test;
    localparam logic [31:0] A_STAT = {22'h000000, `CWISM_IDX_STATUS, 2'b00};
    localparam logic [31:0] A_SYS = {22'h000000, `CWISM_IDX_SYS_MASK, 2'b00};
    localparam logic [31:0] A_CHG = {22'h000000, `CWISM_IDX_CHG_MASK, 2'b00};
    localparam logic [31:0] ZERO = 32'h00000000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic pm_sm_reset = 1'b0;
    logic [15:0] charger_clock_flags = 16'h0000;
    logic [13:0] ev = 14'h0000;
    logic [31:0] rd;
    wire hreadyout;
    wire hresp;
    wire [31:0] hrdata;
    wire irq_request;
    wire [12:0] mask_bits;
    wire [15:0] system_event_mask;
    wire [15:0] charger_clock_event_mask;
    int n_mismatch = 0;
    int num_checks = 0;
    // status bit of each source, the first seven fire on both edges
    int pos[14] = '{15, 14, 13, 11, 10, 9, 8, 6, 5, 4, 3, 2, 1, 0};

    // hsize is ignored by the slave, so it stays at word size
    cwism_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .bus_supply_sense(ev[0]), .adaptor_supply_sense(ev[1]), .battery_sense(ev[2]),
        .left_jack_detect(ev[3]), .right_jack_detect(ev[4]), .mic_short_detect(ev[5]),
        .mic_presence_detect(ev[6]), .wake_cause_off(ev[7]), .wake_cause_hibernate(ev[8]),
        .wake_cause_converter_fault(ev[9]), .wake_cause_watchdog(ev[10]),
        .power_button_pin_held(ev[11]), .on_key_held(ev[12]),
        .wake_request_pin_held(ev[13]), .pm_sm_reset(pm_sm_reset),
        .charger_clock_flags(charger_clock_flags), .irq_request(irq_request),
        .mask_battery_overtemp(mask_bits[12]), .mask_battery_undertemp(mask_bits[11]),
        .mask_battery_failure(mask_bits[10]), .mask_charge_timeout(mask_bits[9]),
        .mask_charge_done(mask_bits[8]), .mask_charge_begun(mask_bits[7]),
        .mask_fast_charge_ready(mask_bits[6]), .mask_clock_periodic(mask_bits[5]),
        .mask_clock_seconds_tick(mask_bits[4]), .mask_clock_alarm(mask_bits[3]),
        .mask_battery_below_high_level(mask_bits[2]),
        .mask_battery_below_mid_level(mask_bits[1]),
        .mask_battery_below_low_level(mask_bits[0]),
        .system_event_mask(system_event_mask),
        .charger_clock_event_mask(charger_clock_event_mask)
    );

    // 25 MHz bus clock
    always #20 hclk = ~hclk;

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge hclk);
    endtask

    // one single transfer; entered just after an edge, each phase held until ready
    task automatic bus(logic [31:0] a, logic w, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rdc(string nm, logic [31:0] a, logic [31:0] exp);
        bus(a, 1'b0, ZERO);
        check(nm, rd, exp);
    endtask

    // request is combinational, so look at it mid-cycle once it has settled
    task automatic irq_is(logic e);
        @(negedge hclk);
        check("irq_request", {31'h0, irq_request}, {31'h0, e});
        @(posedge hclk);
    endtask

    task automatic do_reset;
        hresetn <= 1'b0;
        tick(4);
        hresetn <= 1'b1;
        tick(1);
    endtask

    task automatic t_reset;
        rdc("status", A_STAT, ZERO);
        rdc("sys mask", A_SYS, ZERO);
        rdc("chg mask", A_CHG, ZERO);
        check("hresp", {31'h0, hresp}, ZERO);
        irq_is(1'b0);
        $display("test reset done");
    endtask

    task automatic t_edges;
        for (int i = 0; i < 14; i++) begin
            ev[i] <= 1'b1;
            tick(1);
            irq_is(1'b1);
            rdc("rise", A_STAT, 32'h00000001 << pos[i]);
            rdc("cleared", A_STAT, ZERO);
            ev[i] <= 1'b0;
            tick(2);
            rdc("fall", A_STAT, i < 7 ? 32'h00000001 << pos[i] : ZERO);
        end
        $display("test edges done");
    endtask

    // the event lands on the same edge as the clearing read's address phase
    task automatic t_race;
        ev[0] <= 1'b1;
        bus(A_STAT, 1'b0, ZERO);
        check("race read", rd, ZERO);
        rdc("race kept", A_STAT, 32'h00008000);
        ev[0] <= 1'b0;
        tick(2);
        rdc("race fall", A_STAT, 32'h00008000);
        $display("test race done");
    endtask

    task automatic t_mask;
        bus(A_SYS, 1'b1, 32'hFFFFFFFF);
        rdc("sys mask", A_SYS, 32'h0000FFFF);
        ev[8] <= 1'b1;
        tick(1);
        irq_is(1'b0);
        bus(A_SYS, 1'b1, ZERO);
        irq_is(1'b1);
        rdc("masked flag", A_STAT, 32'h00000020);
        irq_is(1'b0);
        charger_clock_flags <= 16'h0001;
        bus(A_CHG, 1'b1, 32'hFFFFFFFF);
        irq_is(1'b0);
        rdc("chg mask", A_CHG, 32'h0000FEE7);
        check("mask pins", {19'h0, mask_bits}, 32'h00001FFF);
        bus(A_CHG, 1'b1, ZERO);
        irq_is(1'b1);
        charger_clock_flags <= 16'h0000;
        ev[8] <= 1'b0;
        bus(A_STAT, 1'b1, 32'hFFFFFFFF);
        rdc("status write", A_STAT, ZERO);
        bus(32'h00000088, 1'b1, 32'hFFFFFFFF);
        rdc("unmapped", 32'h00000088, ZERO);
        rdc("sys kept", A_SYS, ZERO);
        $display("test mask done");
    endtask

    task automatic t_pm;
        bus(A_SYS, 1'b1, 32'h0000A5A5);
        bus(A_CHG, 1'b1, 32'hFFFFFFFF);
        rdc("sys set", A_SYS, 32'h0000A5A5);
        pm_sm_reset <= 1'b1;
        tick(1);
        pm_sm_reset <= 1'b0;
        rdc("sys pm", A_SYS, ZERO);
        rdc("chg pm", A_CHG, ZERO);
        // leave state behind, then reset in mid-run
        ev[1] <= 1'b1;
        bus(A_SYS, 1'b1, 32'h00001234);
        ev[1] <= 1'b0;
        bus(A_CHG, 1'b1, 32'h00000021);
        // the write lands on the edge the task returns at, so let it settle first
        tick(1);
        check("mask pins odd", {19'h0, mask_bits}, 32'h00000009);
        check("chg word", {16'h0, charger_clock_event_mask}, 32'h00000021);
        check("sys word", {16'h0, system_event_mask}, 32'h00001234);
        do_reset;
        $display("test pm done");
        t_reset;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        do_reset;
        t_reset;
        t_edges;
        t_race;
        t_mask;
        t_pm;
        stop_test;
    end

    // the whole run needs a few hundred cycles
    initial begin
        tick(3000);
        n_mismatch++;
        $display("timeout waiting for the bench");
        stop_test;
    end
endmodule
